// File: ifb_pkg.sv
// Package with register map, bit positions and reset values of the interrupt flag bank.
package ifb_pkg;
  localparam int unsigned DW = 16;
  localparam int unsigned AW = 4;
  localparam int unsigned NSRC = 16;
  localparam logic [AW-1:0] ADDR_CORE_CTRL = 4'h0;
  localparam logic [AW-1:0] ADDR_FLAG0 = 4'h1;
  localparam logic [AW-1:0] ADDR_ENABLE0 = 4'h2;
  localparam logic [AW-1:0] ADDR_PRIO_LO = 4'h3;
  localparam logic [AW-1:0] ADDR_PRIO_HI = 4'h4;
  localparam logic [AW-1:0] ADDR_IRQ_STAT = 4'h5;
  localparam logic [AW-1:0] ADDR_IRQ_MASK = 4'h6;
  localparam logic [AW-1:0] ADDR_CPU_LEVEL = 4'h7;
  localparam int unsigned BIT_NVM = 15;
  localparam int unsigned BIT_ADC = 13;
  localparam int unsigned BIT_UTX = 12;
  localparam int unsigned BIT_URX = 11;
  localparam int unsigned BIT_SPI_EV = 10;
  localparam int unsigned BIT_SPI_FLT = 9;
  localparam int unsigned BIT_T3 = 8;
  localparam int unsigned BIT_T2 = 7;
  localparam int unsigned BIT_CMP2 = 6;
  localparam int unsigned BIT_CAP2 = 5;
  localparam int unsigned BIT_T1 = 3;
  localparam int unsigned BIT_CMP1 = 2;
  localparam int unsigned BIT_CAP1 = 1;
  localparam int unsigned BIT_EXT0 = 0;
  localparam logic [DW-1:0] FLAG_IMPL_MASK = 16'hBFEF;
  localparam logic [DW-1:0] FLAG_RESET = 16'h0000;
  localparam int unsigned BIT_LEVEL_MSB = 3;
  localparam int unsigned LEVEL_LOW_LSB = 5;
  localparam logic [3:0] LEVEL_SEVEN = 4'h7;
  localparam logic [2:0] PRIO_OFF = 3'h0;
  localparam logic [2:0] PRIO_RESET = 3'h4;
  localparam logic [DW-1:0] ZERO_WORD = 16'h0000;
  localparam int unsigned EV_REQ = 0;
  localparam int unsigned EV_LEVEL = 1;
  localparam int unsigned NEV = 2;
endpackage

// File: ifb_prio_pick.sv
// Picks the highest priority pending source; a tie goes to the lower source number.
`timescale 1ns/1ns
module ifb_prio_pick
  import ifb_pkg::*;
(
  input wire logic [ifb_pkg::NSRC-1:0] pend_i,
  input wire logic [3*ifb_pkg::NSRC-1:0] prio_i,
  output logic req_o,
  output logic [3:0] src_o,
  output logic [2:0] prio_o
);
  import ifb_pkg::*;

  always_comb begin
    req_o = 1'b0;
    src_o = 4'h0;
    prio_o = PRIO_OFF;
    for (int i = 0; i < NSRC; i++) begin
      if (pend_i[i] && prio_i[3*i +: 3] != PRIO_OFF && prio_i[3*i +: 3] > prio_o) begin
        req_o = 1'b1;
        src_o = 4'(i);
        prio_o = prio_i[3*i +: 3];
      end
    end
  end
endmodule

// File: ifb_top.sv
// Interrupt flag, enable and priority-level bookkeeping with a register port.
`timescale 1ns/1ns
////////////////////////////////////////////////////////////////////////////////
module ifb_top
  import ifb_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic [ifb_pkg::AW-1:0] addr_i,
  input wire logic [ifb_pkg::DW-1:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [ifb_pkg::DW-1:0] rdata_o,
  input wire logic [ifb_pkg::NSRC-1:0] src_event_i,
  input wire logic [2:0] priority_level_low_i,
  input wire logic level_msb_set_i,
  input wire logic level_msb_clr_i,
  input wire logic program_space_view_i,
  output logic [ifb_pkg::NSRC-1:0] pending_o,
  output logic cpu_req_o,
  output logic [3:0] cpu_src_o,
  output logic [2:0] cpu_prio_o,
  output logic irq_o
);
  import ifb_pkg::*;

  function automatic logic wr_hit(input logic strobe, input logic [AW-1:0] addr,
    input logic [AW-1:0] a);
    return strobe && addr == a;
  endfunction

  function automatic logic rd_hit(input logic strobe, input logic [AW-1:0] addr,
    input logic [AW-1:0] a);
    return strobe && addr == a;
  endfunction

  ////////////////////////////////////////////////////////////////////////////////
  logic [DW-1:0] flag_r, flag_nxt;
  logic [DW-1:0] en_r, en_nxt;
  logic [3*NSRC-1:0] prio_r, prio_nxt;
  logic lvl_msb_r, lvl_msb_nxt;
  logic [NEV-1:0] stat_r, stat_nxt, mask_r, mask_nxt;
  logic [DW-1:0] rdata_r, rdata_nxt;
  logic [NSRC-1:0] pend_r, pend_nxt;
  logic req_r, req_nxt, irq_r, irq_nxt;
  logic [3:0] src_r, src_nxt;
  logic [2:0] pr_r, pr_nxt;
  logic pick_req;
  logic [3:0] pick_src;
  logic [2:0] pick_prio;
  logic [3:0] cpu_level;
  logic [DW-1:0] core_word;
  logic [DW-1:0] evt_map;

  assign cpu_level = {lvl_msb_r, priority_level_low_i};

  always_comb begin
    core_word = ZERO_WORD;
    // only bits 3 and 2 live.
    core_word[BIT_LEVEL_MSB] = lvl_msb_r;
    core_word[BIT_LEVEL_MSB-1] = program_space_view_i;
  end

  // Bits 14 and 4 have no source, so a stray event on those inputs is dropped here.
  // upper flag positions.
  always_comb begin
    evt_map = ZERO_WORD;
    evt_map[BIT_NVM] = src_event_i[BIT_NVM];
    evt_map[BIT_ADC] = src_event_i[BIT_ADC];
    evt_map[BIT_UTX] = src_event_i[BIT_UTX];
    evt_map[BIT_URX] = src_event_i[BIT_URX];
    evt_map[BIT_SPI_EV] = src_event_i[BIT_SPI_EV];
    evt_map[BIT_SPI_FLT] = src_event_i[BIT_SPI_FLT];
    evt_map[BIT_T3] = src_event_i[BIT_T3];
    evt_map[BIT_T2] = src_event_i[BIT_T2];
    evt_map[BIT_CMP2] = src_event_i[BIT_CMP2];
    evt_map[BIT_CAP2] = src_event_i[BIT_CAP2];
    evt_map[BIT_T1] = src_event_i[BIT_T1];
    evt_map[BIT_CMP1] = src_event_i[BIT_CMP1];
    evt_map[BIT_CAP1] = src_event_i[BIT_CAP1];
    evt_map[BIT_EXT0] = src_event_i[BIT_EXT0];
  end

  ////////////////////////////////////////////////////////////////////////////////
  always_comb begin
    flag_nxt = flag_r;
    en_nxt = en_r;
    prio_nxt = prio_r;
    lvl_msb_nxt = lvl_msb_r;
    // software write first, then events win.
    if (wr_hit(wr_i, addr_i, ADDR_FLAG0)) flag_nxt = wdata_i;
    flag_nxt = (flag_nxt | evt_map) & FLAG_IMPL_MASK;
    if (wr_hit(wr_i, addr_i, ADDR_ENABLE0)) en_nxt = wdata_i & FLAG_IMPL_MASK;
    if (wr_hit(wr_i, addr_i, ADDR_PRIO_LO)) prio_nxt[DW-1:0] = wdata_i;
    if (wr_hit(wr_i, addr_i, ADDR_PRIO_HI)) prio_nxt[2*DW-1:DW] = wdata_i;
    if (wr_hit(wr_i, addr_i, ADDR_CPU_LEVEL)) prio_nxt[3*NSRC-1:2*DW] = wdata_i;
    // software can only clear; hardware set wins.
    if (wr_hit(wr_i, addr_i, ADDR_CORE_CTRL) && !wdata_i[BIT_LEVEL_MSB]) lvl_msb_nxt = 1'b0;
    if (level_msb_clr_i) lvl_msb_nxt = 1'b0;
    if (level_msb_set_i) lvl_msb_nxt = 1'b1;
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      flag_r <= FLAG_RESET;
      en_r <= FLAG_RESET;
      prio_r <= {NSRC{PRIO_RESET}};
      lvl_msb_r <= 1'b0;
    end else begin
      flag_r <= flag_nxt;
      en_r <= en_nxt;
      prio_r <= prio_nxt;
      lvl_msb_r <= lvl_msb_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  ifb_prio_pick u_pick (
    .pend_i(flag_r & en_r),
    .prio_i(prio_r),
    .req_o(pick_req),
    .src_o(pick_src),
    .prio_o(pick_prio)
  );

  always_comb begin
    // request needs flag and enable; spi bits gate alike.
    pend_nxt = flag_r & en_r;
    req_nxt = pick_req;
    src_nxt = pick_src;
    pr_nxt = pick_prio;
    stat_nxt = stat_r;
    if (wr_hit(wr_i, addr_i, ADDR_IRQ_STAT)) stat_nxt = stat_r & ~wdata_i[NEV-1:0];
    if (|(flag_r & en_r)) stat_nxt[EV_REQ] = 1'b1;
    // level above seven is an event too.
    if (cpu_level > LEVEL_SEVEN) stat_nxt[EV_LEVEL] = 1'b1;
    mask_nxt = wr_hit(wr_i, addr_i, ADDR_IRQ_MASK) ? wdata_i[NEV-1:0] : mask_r;
    irq_nxt = |(stat_nxt & mask_nxt);
    rdata_nxt = ZERO_WORD;
    if (rd_i) begin
      unique case (addr_i)
        ADDR_CORE_CTRL: rdata_nxt = core_word;
        ADDR_FLAG0: rdata_nxt = flag_r;
        ADDR_ENABLE0: rdata_nxt = en_r;
        ADDR_PRIO_LO: rdata_nxt = prio_r[DW-1:0];
        ADDR_PRIO_HI: rdata_nxt = prio_r[2*DW-1:DW];
        ADDR_CPU_LEVEL: rdata_nxt = prio_r[3*NSRC-1:2*DW];
        ADDR_IRQ_STAT: rdata_nxt = {{(DW-NEV){1'b0}}, stat_r};
        ADDR_IRQ_MASK: rdata_nxt = {{(DW-NEV){1'b0}}, mask_r};
        default: rdata_nxt = ZERO_WORD;
      endcase
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      pend_r <= '0;
      req_r <= 1'b0;
      src_r <= 4'h0;
      pr_r <= PRIO_OFF;
      stat_r <= '0;
      mask_r <= '0;
      irq_r <= 1'b0;
      rdata_r <= ZERO_WORD;
    end else begin
      pend_r <= pend_nxt;
      req_r <= req_nxt;
      src_r <= src_nxt;
      pr_r <= pr_nxt;
      stat_r <= stat_nxt;
      mask_r <= mask_nxt;
      irq_r <= irq_nxt;
      rdata_r <= rdata_nxt;
    end
  end

  assign rdata_o = rdata_r;
  assign pending_o = pend_r;
  assign cpu_req_o = req_r;
  assign cpu_src_o = src_r;
  assign cpu_prio_o = pr_r;
  assign irq_o = irq_r;

  ////////////////////////////////////////////////////////////////////////////////
  default clocking @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);

  flag_set_a: assert property (
    src_event_i[BIT_URX] |=> flag_r[BIT_URX])
    else $error("event did not set flag");
  flag_wr_a: assert property (
    wr_hit(wr_i, addr_i, ADDR_FLAG0) && src_event_i == ZERO_WORD
    |=> flag_r == ($past(wdata_i) & FLAG_IMPL_MASK))
    else $error("flag write lost");
  rd_idle_a: assert property (
    !rd_i |=> rdata_o == ZERO_WORD)
    else $error("read data without strobe");
  nvm_pos_a: assert property (
    src_event_i[BIT_NVM] |=> flag_r[BIT_NVM])
    else $error("nvm flag misplaced");
  adc_pos_a: assert property (
    src_event_i[BIT_ADC] |=> flag_r[BIT_ADC])
    else $error("adc flag misplaced");
  uart_tx_pos_a: assert property (
    src_event_i[BIT_UTX] |=> flag_r[BIT_UTX])
    else $error("uart tx flag misplaced");
  spi_pos_a: assert property (
    src_event_i[BIT_SPI_FLT] |=> flag_r[BIT_SPI_FLT])
    else $error("spi fault flag misplaced");
  spi_event_pos_a: assert property (
    src_event_i[BIT_SPI_EV] |=> flag_r[BIT_SPI_EV])
    else $error("spi event flag misplaced");
  timer3_pos_a: assert property (
    src_event_i[BIT_T3] |=> flag_r[BIT_T3])
    else $error("timer3 flag misplaced");
  timer2_pos_a: assert property (
    src_event_i[BIT_T2] |=> flag_r[BIT_T2])
    else $error("timer2 flag misplaced");
  compare_pos_a: assert property (
    src_event_i[BIT_CMP2] |=> flag_r[BIT_CMP2])
    else $error("compare2 flag misplaced");
  capture_pos_a: assert property (
    src_event_i[BIT_CAP1] |=> flag_r[BIT_CAP1])
    else $error("capture1 flag misplaced");
  ext_pos_a: assert property (
    src_event_i[BIT_EXT0] |=> flag_r[BIT_EXT0])
    else $error("ext0 flag misplaced");
  unused_zero_a: assert property (
    flag_r[14] == 1'b0 && en_r[4] == 1'b0)
    else $error("unimplemented bit set");
  enable_wr_a: assert property (
    wr_hit(wr_i, addr_i, ADDR_ENABLE0) |=> en_r == ($past(wdata_i) & FLAG_IMPL_MASK))
    else $error("enable write lost");
  gate_a: assert property (
    flag_r[BIT_SPI_EV] && !en_r[BIT_SPI_EV] |=> !pending_o[BIT_SPI_EV])
    else $error("spi event not gated");
  fault_gate_a: assert property (
    flag_r[BIT_SPI_FLT] && en_r[BIT_SPI_FLT] |=> pending_o[BIT_SPI_FLT])
    else $error("spi fault not passed");
  impl_mask_a: assert property (
    (flag_r & ~FLAG_IMPL_MASK) == ZERO_WORD && (en_r & ~FLAG_IMPL_MASK) == ZERO_WORD)
    else $error("unimplemented flag or enable bit set");
  level_read_a: assert property (
    rd_hit(rd_i, addr_i, ADDR_CORE_CTRL)
    |=> rdata_o[BIT_LEVEL_MSB] == ($past(cpu_level) > LEVEL_SEVEN))
    else $error("level bit does not follow cpu level");
  level_stat_a: assert property (
    cpu_level > LEVEL_SEVEN |=> stat_r[EV_LEVEL])
    else $error("level event not recorded");
  core_read_a: assert property (
    rd_hit(rd_i, addr_i, ADDR_CORE_CTRL)
    |=> rdata_o[15:4] == 12'h000 && rdata_o[1:0] == 2'h0)
    else $error("core control reserved bits nonzero");
  lvl_set_a: assert property (
    level_msb_set_i |=> lvl_msb_r ##0 (core_word[BIT_LEVEL_MSB] == 1'b1))
    else $error("level bit not set");
  sw_no_set_a: assert property (
    !lvl_msb_r && !level_msb_set_i |=> !lvl_msb_r)
    else $error("level bit set without hardware");
  lvl_clr_a: assert property (
    level_msb_clr_i && !level_msb_set_i |=> !lvl_msb_r)
    else $error("level bit not cleared by hardware");
  sw_clr_a: assert property (
    wr_hit(wr_i, addr_i, ADDR_CORE_CTRL) && !wdata_i[BIT_LEVEL_MSB] && !level_msb_set_i
    |=> !lvl_msb_r)
    else $error("level bit not cleared by software");
  pend_a: assert property (
    pending_o[BIT_T1] |-> $past(flag_r[BIT_T1]) && $past(en_r[BIT_T1]))
    else $error("pending without flag and enable");
  pend_all_a: assert property (
    pending_o == ($past(flag_r) & $past(en_r)))
    else $error("pending does not match flag and enable");
  flag_stick_a: assert property (
    flag_r[BIT_T2] && !wr_hit(wr_i, addr_i, ADDR_FLAG0) |=> flag_r[BIT_T2])
    else $error("flag dropped without software");
  req_pend_a: assert property (
    cpu_req_o |-> pending_o[cpu_src_o])
    else $error("request for source not pending");
  irq_level_a: assert property (
    irq_o == |(stat_r & mask_r))
    else $error("interrupt output does not follow status");
  prio_off_a: assert property (
    cpu_req_o |-> cpu_prio_o != PRIO_OFF)
    else $error("disabled source requested");

  req_c: cover property (cpu_req_o && cpu_prio_o == 3'h7);
  irq_c: cover property (irq_o ##1 wr_hit(wr_i, addr_i, ADDR_IRQ_STAT));
  lvl_c: cover property (lvl_msb_r ##1 !lvl_msb_r);
  fault_c: cover property (pending_o[BIT_SPI_FLT]);
  clr_c: cover property (lvl_msb_r ##1 wr_hit(wr_i, addr_i, ADDR_CORE_CTRL) ##1 !lvl_msb_r);
endmodule

// File: ifb_src_model.sv
// Model of the peripheral event sources that raise requests into the flag bank.
`timescale 1ns/1ns
module ifb_src_model (
  input wire logic clk_i,
  input wire logic [15:0] fire_i,
  input wire logic slow_i,
  output logic [15:0] event_o
);
  logic [15:0] hold_r = 16'h0000;
  // raise request
  // A slow source keeps its request up for a second cycle, as a level source would.
  always_ff @(posedge clk_i) begin
    event_o <= fire_i | (slow_i ? hold_r : 16'h0000);
    hold_r <= fire_i;
  end
endmodule

// File: tb_ifb_top.sv
// Self-checking testbench of the interrupt flag bank.
`timescale 1ns/1ns
module tb_ifb_top;
  import ifb_pkg::*;
  logic clk_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic [AW-1:0] addr_i = 4'h0;
  logic [DW-1:0] wdata_i = 16'h0000;
  logic wr_i = 1'b0, rd_i = 1'b0, rd_d = 1'b0;
  logic [2:0] lvl_lo = 3'h0;
  logic lvl_set = 1'b0, lvl_clr = 1'b0, program_space_view = 1'b0, slow = 1'b0;
  logic [15:0] fire = 16'h0000, ev, en, exp_v;
  logic [DW-1:0] rdata_o;
  logic [NSRC-1:0] pending_o;
  logic cpu_req_o, irq_o;
  logic [3:0] cpu_src_o;
  logic [2:0] cpu_prio_o;
  logic [DW-1:0] exp_q[$];
  logic [3*NSRC-1:0] prio_init = {NSRC{PRIO_RESET}};
  int mismatches = 0, checks_done = 0;
  initial forever #5 clk_i = ~clk_i;
  ifb_src_model ifb_src_model_i (.clk_i(clk_i), .fire_i(fire), .slow_i(slow), .event_o(ev));
  ifb_top ifb_top_i (.clk_i(clk_i), .rst_n_i(rst_n_i), .addr_i(addr_i), .wdata_i(wdata_i),
    .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .src_event_i(ev),
    .priority_level_low_i(lvl_lo), .level_msb_set_i(lvl_set), .level_msb_clr_i(lvl_clr),
    .program_space_view_i(program_space_view), .pending_o(pending_o), .cpu_req_o(cpu_req_o),
    .cpu_src_o(cpu_src_o), .cpu_prio_o(cpu_prio_o), .irq_o(irq_o));
  ////////////////////////////////////////////////////////////////////////////////
  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    checks_done++;
    if (seen !== exp) begin
      mismatches++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clk_i);
  endtask
  task automatic wr(input logic [AW-1:0] a, input logic [DW-1:0] d);
    @(posedge clk_i);
    addr_i <= a;
    wdata_i <= d;
    wr_i <= 1'b1;
    @(posedge clk_i);
    wr_i <= 1'b0;
  endtask
  task automatic rd(input logic [AW-1:0] a, input logic [DW-1:0] exp);
    @(posedge clk_i);
    exp_q.push_back(exp);
    addr_i <= a;
    rd_i <= 1'b1;
    @(posedge clk_i);
    rd_i <= 1'b0;
  endtask
  task automatic pulse_level(input logic set);
    @(posedge clk_i);
    lvl_set <= set;
    lvl_clr <= !set;
    @(posedge clk_i);
    lvl_set <= 1'b0;
    lvl_clr <= 1'b0;
    cyc(3);
  endtask
  // The read data stand only in the cycle after the strobe, so they are taken at that edge.
  always @(posedge clk_i) begin
    if (rd_d) check("rdata", rdata_o, exp_q.pop_front());
    rd_d <= rd_i;
  end
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  initial begin
    #200000;
    mismatches++;
    wrap_up();
  end
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    void'($urandom(32'h26FE));
    cyc(12);
    rst_n_i <= 1'b1;
    for (int a = 0; a < 3; a++) rd(a[AW-1:0], 16'h0000);
    rd(4'hF, 16'h0000);
    rd(ADDR_PRIO_LO, prio_init[15:0]);
    rd(ADDR_PRIO_HI, prio_init[31:16]);
    rd(ADDR_CPU_LEVEL, prio_init[47:32]);
    rd(ADDR_IRQ_STAT, 16'h0000);
    rd(ADDR_IRQ_MASK, 16'h0000);
    wr(ADDR_FLAG0, 16'hFFFF);
    wr(ADDR_ENABLE0, 16'hFFFF);
    rd(ADDR_FLAG0, 16'hBFEF);
    rd(ADDR_ENABLE0, 16'hBFEF);
    $display("test register map done");
    for (int b = 0; b < 16; b++) begin
      en = 16'($urandom());
      wr(ADDR_FLAG0, 16'h0000);
      wr(ADDR_ENABLE0, en);
      slow <= b[0];
      fire <= 16'h0001 << b;
      @(posedge clk_i);
      fire <= 16'h0000;
      cyc(5);
      exp_v = (16'h0001 << b) & 16'hBFEF;
      check("pending", pending_o, exp_v & en);
      rd(ADDR_FLAG0, exp_v);
    end
    $display("test event sources done");
    program_space_view <= 1'($urandom());
    lvl_lo <= 3'($urandom());
    pulse_level(1'b1);
    rd(ADDR_CORE_CTRL, {12'h000, 1'b1, program_space_view, 2'b00});
    wr(ADDR_CORE_CTRL, 16'h0000);
    rd(ADDR_CORE_CTRL, {13'h0000, program_space_view, 2'b00});
    pulse_level(1'b1);
    pulse_level(1'b0);
    wr(ADDR_CORE_CTRL, 16'hFFFF);
    rd(ADDR_CORE_CTRL, {13'h0000, program_space_view, 2'b00});
    $display("test level bit done");
    wr(ADDR_IRQ_MASK, 16'h0000);
    wr(ADDR_ENABLE0, 16'h0003);
    wr(ADDR_FLAG0, 16'h0001);
    cyc(4);
    check("irq masked", {15'h0000, irq_o}, 16'h0000);
    wr(ADDR_IRQ_MASK, 16'h0001);
    cyc(4);
    check("irq", {15'h0000, irq_o}, 16'h0001);
    rd(ADDR_IRQ_MASK, 16'h0001);
    wr(ADDR_FLAG0, 16'h0000);
    cyc(3);
    wr(ADDR_IRQ_STAT, 16'h0001);
    cyc(4);
    check("irq cleared", {15'h0000, irq_o}, 16'h0000);
    rd(ADDR_IRQ_STAT, 16'h0002);
    $display("test interrupt done");
    wr(ADDR_PRIO_LO, 16'h0000);
    wr(ADDR_FLAG0, 16'h0001);
    cyc(4);
    check("req off", {15'h0000, cpu_req_o}, 16'h0000);
    wr(ADDR_PRIO_LO, 16'h0027);
    wr(ADDR_FLAG0, 16'h0003);
    cyc(4);
    check("req", {15'h0000, cpu_req_o}, 16'h0001);
    check("src", {12'h000, cpu_src_o}, 16'h0000);
    check("prio", {13'h0000, cpu_prio_o}, 16'h0007);
    $display("test priority done");
    cyc(3);
    wrap_up();
  end
endmodule
